// ### include/saroc_pkg.sv
// saroc_pkg: constants, carrier types and the output coding for the converter control block.
// assumes one 20 MHz system clock; every pin-side time is counted in cycles of that clock.
package saroc_pkg;

   localparam int CLK_PERIOD_NS = 50;
   localparam int CONV_TIME_NS = 20000;
   localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SCLK_HALF_NS = 200;
   localparam int SCLK_HALF_CYCLES = (SCLK_HALF_NS / CLK_PERIOD_NS < 1) ? 1 :
                                     SCLK_HALF_NS / CLK_PERIOD_NS;
   localparam int RESULT_W = 16;
   localparam int BYTE_W = 8;
   localparam int SERIAL_BITS = 16;

   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_MASK = 8'h04;
   localparam logic [7:0] OFS_RESULT = 8'h08;
   localparam logic [7:0] OFS_CTRL = 8'h0C;

   localparam int EVENT_W = 3;
   localparam int STB_CONV_DONE = 0;
   localparam int STB_SER_DONE = 1;
   localparam int STB_IGNORED = 2;
   localparam int STB_SLEEP = 8;
   localparam int STB_VREF_OFF = 9;
   localparam int STB_BUSY = 10;
   localparam int CTRL_START = 0;
   localparam logic [2:0] MASK_RESET = 3'h0;
   localparam logic [2:0] STATUS_RESET = 3'h0;
   localparam logic [15:0] RESULT_RESET = 16'h0000;

   typedef struct packed {
      logic csN;
      logic rcN;
      logic halfSel;
      logic fmtSel;
      logic clkSrc;
      logic sclkIn;
      logic chainIn;
      logic sleep;
      logic vrefDis;
   } saroc_pins_t;

   // idle pin levels: select and read/convert high so no start is seen at release;
   // clock source reads external until synced, so the clock pin never fights a host clock
   localparam saroc_pins_t PINS_RESET = '{csN: 1'b1, rcN: 1'b1, halfSel: 1'b0, fmtSel: 1'b0,
                                          clkSrc: 1'b1, sclkIn: 1'b0, chainIn: 1'b0,
                                          sleep: 1'b0, vrefDis: 1'b0};

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_CONV = 3'b010,
      ST_SERWAIT = 3'b100
   } saroc_state_t;

   // the converter core delivers two's complement; straight binary flips the sign bit
   function automatic logic [15:0] saroc_format(input logic [15:0] code, input logic straight);
      saroc_format = {code[15] ^ straight, code[14:0]};
   endfunction

endpackage

// ### design/saroc_sync.sv
// saroc_sync: three-stage input synchroniser for asynchronous pins.
// assumes inputs may change at any time; output moves only once stages two and three agree.
`timescale 1ns/10ps
`default_nettype none
module saroc_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RESET_VAL = '0
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] stage1_q;
   logic [W-1:0] stage2_q;
   logic [W-1:0] stage3_q;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         stage1_q <= RESET_VAL;
         stage2_q <= RESET_VAL;
         stage3_q <= RESET_VAL;
      end else begin
         stage1_q <= din;
         stage2_q <= stage1_q;
         stage3_q <= stage2_q;
      end
   end

   // per bit: take the new level only when two settled stages agree
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         dout <= RESET_VAL;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (stage2_q[i] == stage3_q[i]) begin
               dout[i] <= stage3_q[i];
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### design/saroc_serial.sv
// saroc_serial: 16-bit result shifter, internal clock generation or external clock following.
// assumes the external clock level arrives already synchronised to the system clock.
`timescale 1ns/10ps
`default_nettype none
module saroc_serial #(
   parameter int HALF = saroc_pkg::SCLK_HALF_CYCLES,
   parameter int BITS = saroc_pkg::SERIAL_BITS
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic extMode,
   input wire logic load,
   input wire logic [15:0] word,
   input wire logic extClk,
   input wire logic chainIn,
   output logic sclkOut,
   output logic dataOut,
   output logic active,
   output logic donePulse
);
   localparam int DW = $clog2(HALF + 1);
   localparam int BW = $clog2(BITS + 1);
   logic [15:0] shift_q;
   logic [DW-1:0] div_q;
   logic [BW-1:0] bitCnt_q;
   logic extPrev_q;
   logic tick;
   logic intFall;
   logic extFall;

   assign tick = active && (div_q == DW'(HALF - 1));
   assign intFall = tick && sclkOut;
   assign extFall = extMode && extPrev_q && !extClk;
   assign dataOut = shift_q[15];

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         extPrev_q <= 1'b0;
      end else begin
         extPrev_q <= extClk;
      end
   end

   // internal clock: a divider enable toggles the line, bits move on its falling edge
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         div_q <= '0;
         sclkOut <= 1'b0;
         active <= 1'b0;
         bitCnt_q <= '0;
         donePulse <= 1'b0;
      end else begin
         donePulse <= 1'b0;
         if (load && !extMode) begin
            active <= 1'b1;
            div_q <= '0;
            sclkOut <= 1'b0;
            bitCnt_q <= '0;
         end else if (active) begin
            div_q <= tick ? '0 : div_q + DW'(1);
            if (tick) begin
               sclkOut <= !sclkOut;
            end
            if (intFall) begin
               bitCnt_q <= bitCnt_q + BW'(1);
               if (bitCnt_q == BW'(BITS - 1)) begin
                  active <= 1'b0;
                  donePulse <= 1'b1;
               end
            end
         end
      end
   end

   // msb leaves first; in external mode the chain input refills from the bottom
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         shift_q <= '0;
      end else if (load) begin
         shift_q <= word;
      end else if (intFall) begin
         shift_q <= {shift_q[14:0], 1'b0};
      end else if (extFall) begin
         shift_q <= {shift_q[14:0], chainIn};
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   logic [BW:0] pulses_q;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pulses_q <= '0;
      end else if (load && !extMode) begin
         pulses_q <= '0;
      end else if (tick && !sclkOut) begin
         pulses_q <= pulses_q + (BW + 1)'(1);
      end
   end

   a_sixteen_pulses: assert property (donePulse |-> pulses_q == (BW + 1)'(BITS))
      else $error("serial frame did not carry sixteen clock pulses");
   a_msb_first: assert property (load |=> dataOut == $past(word[15]))
      else $error("serial data did not start with the msb");
   a_chain_fill: assert property (extFall && !load |=> shift_q[0] == $past(chainIn))
      else $error("chain input not shifted in on external clock fall");
   a_int_idle: assert property (extMode && !active |-> !sclkOut)
      else $error("internal serial clock toggling in external mode");
   c_serial_frame: cover property (donePulse);
endmodule
`default_nettype wire

// ### design/saroc_ctrl.sv
// saroc_ctrl: conversion control, result register, parallel and serial output, ahb-lite registers.
// assumes control pins are asynchronous to clock, sarCode is valid from the analog core at the
// end of the conversion time, and the pad ring resolves outputs from their enables.
`timescale 1ns/10ps
`default_nettype none
module saroc_ctrl #(
   parameter int CONV_CYCLES = saroc_pkg::CONV_CYCLES,
   parameter int SCLK_HALF = saroc_pkg::SCLK_HALF_CYCLES
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic chipSelectN,
   input wire logic readConvertN,
   input wire logic halfSelect,
   input wire logic formatSelect,
   input wire logic clockSourceSelect,
   input wire logic serialShiftClockIn,
   input wire logic chainSerialIn,
   input wire logic analogSleep,
   input wire logic vrefDisable,
   input wire logic [15:0] sarCode,
   output logic [7:0] parallelOut,
   output logic [7:0] parallelOutOe,
   output logic serialShiftClockOut,
   output logic serialShiftClockOe,
   output logic serialResultOut,
   output logic busyN,
   output logic sampleHold,
   output logic analogPowerDown,
   output logic referencePowerDown,
   output logic irq,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata
);
   localparam int CW = $clog2(CONV_CYCLES + 1);

   saroc_pkg::saroc_pins_t pinRaw;
   saroc_pkg::saroc_pins_t pinS;
   saroc_pkg::saroc_state_t state_q;
   logic ctrlPrev_q;
   logic ctrlHigh;
   logic pinStart;
   logic softStart;
   logic request;
   logic accepted;
   logic ignored;
   logic [CW-1:0] convCnt_q;
   logic convEnd;
   logic [15:0] result_q;
   logic [15:0] fmtWord;
   logic serLoad;
   logic [15:0] serWord;
   logic serActive;
   logic serDone;
   logic [2:0] events;
   logic [2:0] status_q;
   logic [2:0] mask_q;
   logic addrAcc;
   logic statusRead;
   logic wrPend_q;
   logic [7:0] wrAddr_q;
   logic [31:0] readValue;

   assign pinRaw = '{csN: chipSelectN, rcN: readConvertN, halfSel: halfSelect,
                     fmtSel: formatSelect, clkSrc: clockSourceSelect,
                     sclkIn: serialShiftClockIn, chainIn: chainSerialIn,
                     sleep: analogSleep, vrefDis: vrefDisable};

   saroc_sync #(
      .W($bits(saroc_pkg::saroc_pins_t)),
      .RESET_VAL(saroc_pkg::PINS_RESET)
   ) uSync (
      .clock(clock),
      .reset(reset),
      .din(pinRaw),
      .dout(pinS)
   );

   // start detection: the two controls act as one ORed level, so either falling last starts
   assign ctrlHigh = pinS.csN | pinS.rcN;
   assign pinStart = ctrlPrev_q && !ctrlHigh;
   assign request = pinStart || softStart;
   assign accepted = request && (state_q == saroc_pkg::ST_IDLE);
   assign ignored = request && (state_q != saroc_pkg::ST_IDLE);
   assign convEnd = (state_q == saroc_pkg::ST_CONV) && (convCnt_q == CW'(CONV_CYCLES - 1));

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ctrlPrev_q <= 1'b1;
      end else begin
         ctrlPrev_q <= ctrlHigh;
      end
   end

   // conversion sequencer; in internal-clock mode busy also covers the serial frame
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_q <= saroc_pkg::ST_IDLE;
         convCnt_q <= '0;
      end else begin
         case (state_q)
            saroc_pkg::ST_IDLE: begin
               if (accepted) begin
                  state_q <= saroc_pkg::ST_CONV;
                  convCnt_q <= '0;
               end
            end
            saroc_pkg::ST_CONV: begin
               convCnt_q <= convCnt_q + CW'(1);
               if (convEnd) begin
                  state_q <= serActive ? saroc_pkg::ST_SERWAIT : saroc_pkg::ST_IDLE;
               end
            end
            saroc_pkg::ST_SERWAIT: begin
               if (!serActive) begin
                  state_q <= saroc_pkg::ST_IDLE;
               end
            end
            default: begin
               state_q <= saroc_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // busy is the idle bit of the one-hot state, so it rises with the result already stored
   assign busyN = state_q[0];
   assign sampleHold = state_q[1];

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         result_q <= saroc_pkg::RESULT_RESET;
      end else if (convEnd) begin
         result_q <= sarCode;
      end
   end

   assign fmtWord = saroc_pkg::saroc_format(result_q, pinS.fmtSel);

   // parallel port: registered byte and enables; drivers only while select low, read/convert high
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         parallelOut <= '0;
         parallelOutOe <= '0;
      end else begin
         parallelOut <= pinS.halfSel ? fmtWord[7:0] : fmtWord[15:8];
         parallelOutOe <= {8{!pinS.csN && pinS.rcN}};
      end
   end

   // internal clock: the starting edge ships the previous result; external: each new result
   assign serLoad = pinS.clkSrc ? convEnd : accepted;
   assign serWord = pinS.clkSrc ? saroc_pkg::saroc_format(sarCode, pinS.fmtSel) : fmtWord;

   saroc_serial #(
      .HALF(SCLK_HALF),
      .BITS(saroc_pkg::SERIAL_BITS)
   ) uSerial (
      .clock(clock),
      .reset(reset),
      .extMode(pinS.clkSrc),
      .load(serLoad),
      .word(serWord),
      .extClk(pinS.sclkIn),
      .chainIn(pinS.chainIn & pinS.clkSrc),
      .sclkOut(serialShiftClockOut),
      .dataOut(serialResultOut),
      .active(serActive),
      .donePulse(serDone)
   );

   // pad controls; sleep and reference disable leave all digital logic running
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         serialShiftClockOe <= 1'b0;
         analogPowerDown <= 1'b0;
         referencePowerDown <= 1'b0;
      end else begin
         serialShiftClockOe <= !pinS.clkSrc;
         analogPowerDown <= pinS.sleep;
         referencePowerDown <= pinS.vrefDis;
      end
   end

   // ahb-lite slave: zero wait states, always okay, read data registered in the address phase
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign addrAcc = hsel && htrans[1] && hready;
   assign statusRead = addrAcc && !hwrite && (haddr[7:0] == saroc_pkg::OFS_STATUS);
   assign softStart = wrPend_q && (wrAddr_q == saroc_pkg::OFS_CTRL) &&
                      hwdata[saroc_pkg::CTRL_START];

   always_comb begin
      readValue = 32'h00000000;
      case (haddr[7:0])
         saroc_pkg::OFS_STATUS: begin
            readValue[2:0] = status_q;
            readValue[saroc_pkg::STB_SLEEP] = pinS.sleep;
            readValue[saroc_pkg::STB_VREF_OFF] = pinS.vrefDis;
            readValue[saroc_pkg::STB_BUSY] = !busyN;
         end
         saroc_pkg::OFS_MASK: begin
            readValue[2:0] = mask_q;
         end
         saroc_pkg::OFS_RESULT: begin
            readValue[15:0] = result_q;
         end
         default: begin
            readValue = 32'h00000000;
         end
      endcase
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         hrdata <= 32'h00000000;
         wrPend_q <= 1'b0;
         wrAddr_q <= 8'h00;
      end else begin
         wrPend_q <= addrAcc && hwrite;
         if (addrAcc) begin
            wrAddr_q <= haddr[7:0];
         end
         if (addrAcc && !hwrite) begin
            hrdata <= readValue;
         end
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         mask_q <= saroc_pkg::MASK_RESET;
      end else if (wrPend_q && (wrAddr_q == saroc_pkg::OFS_MASK)) begin
         mask_q <= hwdata[2:0];
      end
   end

   // sticky events: a read clears, an event in the same cycle survives the clear
   assign events = {ignored, serDone, convEnd};

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         status_q <= saroc_pkg::STATUS_RESET;
      end else begin
         status_q <= (statusRead ? 3'h0 : status_q) | events;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_q & mask_q);
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   a_busy_start: assert property (accepted |=> !busyN [*8])
      else $error("busy not held low after a conversion start");
   a_busy_until_store: assert property (convEnd |=> result_q == $past(sarCode) &&
                                         (busyN || serActive))
      else $error("busy released without result stored");
   a_ignore_busy: assert property ((request && state_q == saroc_pkg::ST_CONV && !convEnd)
                                   |=> convCnt_q == $past(convCnt_q) + CW'(1))
      else $error("request during busy restarted the conversion");
   a_edge_start: assert property ((ctrlHigh && busyN) ##1 !ctrlHigh |=> !busyN)
      else $error("combined control fall did not start a conversion");
   a_hiz_gate: assert property ((pinS.csN || !pinS.rcN) |=> parallelOutOe == 8'h00)
      else $error("parallel drivers on while deselected");
   a_drive_on: assert property ((!pinS.csN && pinS.rcN) |=> parallelOutOe == 8'hFF)
      else $error("parallel drivers not enabled");
   a_byte_select: assert property (##1 parallelOut == ($past(pinS.halfSel) ?
                                   $past(fmtWord[7:0]) : $past(fmtWord[15:8])))
      else $error("wrong byte on the parallel port");
   // straight binary is two's complement moved up by half the range
   a_format_sign: assert property (fmtWord ==
                                   (pinS.fmtSel ? result_q + 16'h8000 : result_q))
      else $error("output coding does not follow the format pin");
   a_sclk_dir: assert property (##1 serialShiftClockOe == !$past(pinS.clkSrc))
      else $error("serial clock direction wrong");
   a_result_hold: assert property (!convEnd |=> $stable(result_q))
      else $error("result changed outside conversion end");
   a_prev_sent: assert property ((accepted && !pinS.clkSrc) |=> serActive &&
                                 serialResultOut == $past(fmtWord[15]))
      else $error("previous result not sent on start");
   a_sleep_live: assert property (pinS.sleep && request && busyN |=> !busyN)
      else $error("logic stopped while analog sleep");
   a_irq_level: assert property (##1 irq == |($past(status_q) & $past(mask_q)))
      else $error("interrupt level does not follow status and mask");
   a_status_sticky: assert property (status_q[0] && !statusRead |=> status_q[0])
      else $error("conversion done flag lost without a status read");
   a_read_clears: assert property (statusRead && !events[0] |=> !status_q[0])
      else $error("status read did not clear the conversion done flag");
   a_hold_phase: assert property (accepted |=> sampleHold && !busyN)
      else $error("sample hold not entered on conversion start");

   // busy-low run length, counted apart from the sequencer so a counter slip shows up
   logic [CW:0] busyLen_q;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         busyLen_q <= '0;
      end else if (busyN) begin
         busyLen_q <= '0;
      end else begin
         busyLen_q <= busyLen_q + (CW + 1)'(1);
      end
   end

   a_conv_length: assert property (convEnd |->
                                   busyLen_q == (CW + 1)'(CONV_CYCLES - 1))
      else $error("conversion time differs from the configured count");

   c_conversion: cover property (accepted ##[1:1000] busyN);
   c_ignored: cover property (ignored);
   c_par_read: cover property (parallelOutOe == 8'hFF && busyN);
   c_serial_wait: cover property (state_q == saroc_pkg::ST_SERWAIT);
endmodule
`default_nettype wire

// ### verif/saroc_host_model.sv
// saroc_host_model: host side of the converter pins, the control strobes and the external data clock.
// assumes the bench calls its tasks by hierarchical name; clock is the block's system clock.
`timescale 1ns/10ps
`default_nettype none
module saroc_host_model (
   input wire logic clock,
   input wire logic dataIn,
   output logic csN,
   output logic rcN,
   output logic sclkIn,
   output logic chainIn
);
   initial begin
      csN = 1'b1;
      rcN = 1'b1;
      sclkIn = 1'b0;
      chainIn = 1'b0;
   end
   task automatic pins(input logic cs, input logic rc);
      @(posedge clock);
      csN <= cs;
      rcN <= rc;
   endtask
   // start only while idle; six cycles low sits well inside the allowed window
   // the other control falls two cycles ahead, so the chosen one makes the starting edge
   task automatic convert(input logic viaCs);
      @(posedge clock);
      if (viaCs) begin
         rcN <= 1'b0;
      end else begin
         csN <= 1'b0;
      end
      repeat (2) @(posedge clock);
      csN <= 1'b0;
      rcN <= 1'b0;
      repeat (6) @(posedge clock);
      rcN <= 1'b1; // released long before busy can rise
   endtask
   // clock stands low outside a frame; 400 ns period, bit taken late in the high half
   task automatic frame(input logic chain, output logic [15:0] bits);
      @(posedge clock);
      chainIn <= chain;
      for (int i = 0; i < 16; i++) begin
         sclkIn <= 1'b1;
         repeat (4) @(posedge clock);
         bits = {bits[14:0], dataIn};
         sclkIn <= 1'b0;
         repeat (4) @(posedge clock);
      end
      chainIn <= ~chain;
   endtask
endmodule
`default_nettype wire

// ### verif/tb_sar_adc_conversion_output_ctrl.sv
// tb_sar_adc_conversion_output_ctrl: self-checking bench for saroc_ctrl with a host pin model.
// assumes a shortened conversion count; expectations come from a small model kept here.
`timescale 1ns/10ps
`default_nettype none
module tb_sar_adc_conversion_output_ctrl;
   logic clock, reset, halfSelect, formatSelect, clockSourceSelect, analogSleep, vrefDisable;
   logic csN, rcN, sclkIn, chainIn, hsel, hwrite, hready, sclkPrev;
   logic sclkOut, sclkOe, sOut, busyN, sh, apd, rpd, irq, hreadyout, hresp;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] pOut, pOe;
   logic [15:0] sarCode, res, prevFmt, bits, eBits;
   logic [31:0] haddr, hwdata, hrdata, rd, rnd;
   int fail_count, check_count, pulses, p0;
   assign hready = hreadyout;
   saroc_ctrl #(.CONV_CYCLES(20), .SCLK_HALF(4)) dut_u (.clock(clock), .reset(reset),
      .chipSelectN(csN), .readConvertN(rcN), .halfSelect(halfSelect),
      .formatSelect(formatSelect), .clockSourceSelect(clockSourceSelect),
      .serialShiftClockIn(sclkIn), .chainSerialIn(chainIn), .analogSleep(analogSleep),
      .vrefDisable(vrefDisable), .sarCode(sarCode), .parallelOut(pOut), .parallelOutOe(pOe),
      .serialShiftClockOut(sclkOut), .serialShiftClockOe(sclkOe), .serialResultOut(sOut),
      .busyN(busyN), .sampleHold(sh), .analogPowerDown(apd), .referencePowerDown(rpd),
      .irq(irq), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
   saroc_host_model host (.clock(clock), .dataIn(sOut), .csN(csN), .rcN(rcN),
      .sclkIn(sclkIn), .chainIn(chainIn));
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   // serial bits are stable at the rising edge because they move on the falling one
   always @(posedge clock) begin
      if (sclkOut === 1'b1 && sclkPrev === 1'b0) begin
         bits <= {bits[14:0], sOut};
         pulses <= pulses + 1;
      end
      sclkPrev <= sclkOut;
   end
   function automatic logic [15:0] xs();
      rnd = rnd ^ (rnd << 13);
      rnd = rnd ^ (rnd >> 17);
      rnd = rnd ^ (rnd << 5);
      return rnd[15:0];
   endfunction
   function automatic logic [15:0] fmt(input logic [15:0] c, input logic sb);
      return {c[15] ^ sb, c[14:0]};
   endfunction
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic waitRdy();
      int n;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (hready !== 1'b1 && n < 50);
      if (hready !== 1'b1) begin
         fail_count++;
         test_done();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clock);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      waitRdy();
      htrans <= 2'h0;
      hwdata <= wd;
      waitRdy();
      rd = hrdata;
      chk("hresp", hresp, 32'h0);
   endtask
   task automatic waitBusy(input logic lvl);
      int n;
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (busyN !== lvl && n < 400);
      if (busyN !== lvl) begin
         fail_count++;
         test_done();
      end
   endtask
   task automatic conv(input logic viaCs, input logic tryCtrl);
      @(posedge clock);
      sarCode <= xs();
      host.convert(viaCs);
      waitBusy(1'b0);
      chk("hold", sh, 32'h1);
      bus(1'b0, 8'h08, 32'h0);
      chk("old result", rd, {16'h0, res});
      if (tryCtrl) begin
         bus(1'b1, 8'h0C, 32'h1);
      end
      waitBusy(1'b1);
      res = sarCode;
   endtask
   task automatic post(input logic ign, input logic ser);
      logic [15:0] e;
      repeat (4) @(negedge clock);
      chk("irq", irq, 32'h1);
      chk("apd", apd, analogSleep);
      chk("rpd", rpd, vrefDisable);
      bus(1'b0, 8'h08, 32'h0);
      chk("result", rd, {16'h0, res});
      bus(1'b0, 8'h00, 32'h0);
      chk("status", rd, {22'h0, vrefDisable, analogSleep, 5'h0, ign, ser, 1'b1});
      repeat (4) @(negedge clock);
      chk("irq", irq, 32'h0);
      for (int i = 0; i < 4; i++) begin
         @(posedge clock);
         formatSelect <= i[0];
         halfSelect <= i[1];
         repeat (6) @(negedge clock);
         e = fmt(res, i[0]);
         chk("oe", pOe, 32'hFF);
         chk("byte", pOut, i[1] ? e[7:0] : e[15:8]);
      end
      host.pins(1'b1, 1'b0);
      repeat (6) @(negedge clock);
      chk("oe", pOe, 32'h0);
      chk("busy", busyN, 32'h1);
      host.pins(1'b1, 1'b1);
   endtask
   initial begin
      rnd = 32'hC3C9;
      fail_count = 0;
      check_count = 0;
      res = 16'h0;
      reset = 1'b1;
      {halfSelect, formatSelect, analogSleep, vrefDisable, hsel, hwrite} = 6'h0;
      clockSourceSelect = 1'b1;
      sarCode = 16'h0;
      {haddr, hwdata} = 64'h0;
      htrans = 2'h0;
      hsize = 3'h2;
      repeat (3) @(posedge clock);
      reset <= 1'b0;
      repeat (2) @(negedge clock);
      chk("busy", busyN, 32'h1);
      chk("oe", pOe, 32'h0);
      bus(1'b1, 8'h04, 32'h1);
      bus(1'b0, 8'h04, 32'h0);
      chk("mask", rd, 32'h1);
      bus(1'b0, 8'h40, 32'h0);
      chk("unmapped", rd, 32'h0);
      for (int k = 0; k < 3; k++) begin
         @(posedge clock);
         analogSleep <= k[0];
         vrefDisable <= k[1];
         conv(k[0], k == 1);
         post(k == 1, 1'b0);
      end
      @(posedge clock);
      clockSourceSelect <= 1'b0;
      repeat (6) @(negedge clock);
      chk("sclk oe", sclkOe, 32'h1);
      prevFmt = fmt(res, formatSelect);
      p0 = pulses;
      conv(1'b1, 1'b0);
      chk("pulses", pulses - p0, 32'h10);
      chk("serial", bits, prevFmt);
      post(1'b0, 1'b1);
      @(posedge clock);
      clockSourceSelect <= 1'b1;
      conv(1'b0, 1'b0);
      chk("sclk oe", sclkOe, 32'h0);
      host.frame(rnd[0], eBits);
      chk("serial", eBits, fmt(res, formatSelect));
      repeat (6) @(negedge clock);
      chk("chain", sOut, rnd[0]);
      test_done();
   end
endmodule
`default_nettype wire
